// ### hdl/dsp_mac_pkg.sv
// shared constants and types of the multiply-accumulate datapath
`default_nettype none
package dsp_mac_pkg;
    localparam int ACC_W = 40;
    localparam int PROD_W = 33;
    localparam int ACC_MSB = 39;
    localparam int GUARD_LO = 32;
    localparam int APB_AW = 8;
    // register byte offsets
    localparam logic [APB_AW-1:0] OFF_CORE_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFF_INT_CTRL = 8'h04;
    localparam logic [APB_AW-1:0] OFF_STATUS = 8'h08;
    localparam logic [APB_AW-1:0] OFF_ACCA_LO = 8'h0c;
    localparam logic [APB_AW-1:0] OFF_ACCA_HI = 8'h10;
    localparam logic [APB_AW-1:0] OFF_ACCB_LO = 8'h14;
    localparam logic [APB_AW-1:0] OFF_ACCB_HI = 8'h18;
    localparam logic [APB_AW-1:0] OFF_MUL_RES = 8'h1c;
    // core control fields
    localparam int CC_FRAC_BIT = 0;
    localparam int CC_SATW_BIT = 4;
    localparam int CC_SAT_EN_B_BIT = 6;
    localparam int CC_SAT_EN_A_BIT = 7;
    localparam logic [7:0] CC_WMASK = 8'hd1;
    localparam logic [7:0] CC_RESET = 8'h01;
    // interrupt control one fields
    localparam int IC_TRAP_EN_A_BIT = 0;
    localparam int IC_TRAP_EN_B_BIT = 1;
    localparam logic [1:0] IC_RESET = 2'h0;
    // status fields, same order as dsp_status_type
    localparam int ST_SAT_A_BIT = 2;
    localparam int ST_SAT_B_BIT = 3;
    localparam logic [5:0] ST_RESET = 6'h00;
    localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
    // clamp values
    localparam logic [ACC_W-1:0] SAT31_POS = 40'h00_7fff_ffff;
    localparam logic [ACC_W-1:0] SAT31_NEG = 40'hff_8000_0000;
    localparam logic [ACC_W-1:0] SAT39_POS = 40'h7f_ffff_ffff;
    localparam logic [ACC_W-1:0] SAT39_NEG = 40'h80_0000_0000;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_MAC = 3'h1,
        OP_ADD = 3'h3,
        OP_LOAD = 3'h2,
        OP_IMUL = 3'h6
    } op_kind_type;

    typedef struct packed {
        op_kind_type kind;
        logic accSel;
        logic subtract;
        logic xSigned;
        logic ySigned;
        logic byteOps;
        logic signed [4:0] shiftAmt;
        logic [15:0] dataX;
        logic [15:0] dataY;
        logic [15:0] dataIn;
    } dsp_op_type;

    typedef struct packed {
        logic combinedSaturated;
        logic combinedGuardOverflow;
        logic accBSaturated;
        logic accASaturated;
        logic accBGuardOverflow;
        logic accAGuardOverflow;
    } dsp_status_type;
endpackage : dsp_mac_pkg
`default_nettype wire

// ### hdl/mac_multiplier.sv
// 17x17 multiplier with integer or fractional output scaler
`default_nettype none
module mac_multiplier
    import dsp_mac_pkg::*;
(
    // clock and reset, used by the checks only
    input wire logic clk_sys,
    input wire logic reset,
    // operands and mode
    input wire logic [15:0] opX,
    input wire logic [15:0] opY,
    input wire logic xSigned,
    input wire logic ySigned,
    input wire logic fractional,
    // result
    output logic [PROD_W-1:0] product
);
    logic signed [16:0] xExt;
    logic signed [16:0] yExt;
    logic signed [33:0] fullProduct;

    assign xExt = {xSigned & opX[15], opX};
    assign yExt = {ySigned & opY[15], opY};
    assign fullProduct = xExt * yExt;
    // fractional: q15 x q15 gives q30, one left shift aligns it to 1.31
    assign product = fractional ? {fullProduct[31:0], 1'b0} : fullProduct[32:0];

    property p_zero_ext;
        @(posedge clk_sys) disable iff (reset)
        !xSigned |-> (xExt[16] == 1'b0) && (product[32] == 1'b0 || ySigned);
    endproperty
    a_zero_ext: assert property (p_zero_ext) else $error("unsigned operand not zero extended");

    property p_sign_ext;
        @(posedge clk_sys) disable iff (reset)
        ySigned |-> yExt[16] == opY[15];
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("signed operand not sign extended");

    property p_frac_minus_one;
        @(posedge clk_sys) disable iff (reset)
        (fractional && xSigned && ySigned && opX == 16'h8000 && opY == 16'h8000)
            |-> product == 33'h0_8000_0000;
    endproperty
    a_frac_minus_one: assert property (p_frac_minus_one) else $error("-1.0 squared wrong");
endmodule : mac_multiplier
`default_nettype wire

// ### hdl/dsp_multiply_accumulate_unit.sv
// multiply-accumulate datapath with saturation, overflow status and an apb register port
`default_nettype none
module dsp_multiply_accumulate_unit
    import dsp_mac_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // instruction decoder
    input wire logic opValid,
    input wire dsp_op_type opIn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // results to core
    output logic [31:0] mulResult,
    output logic mulValid,
    output dsp_status_type statusOut,
    output logic trapRequest
);
    logic [7:0] coreControlReg;
    logic [1:0] interruptControlOne;
    logic [ACC_W-1:0] accumulator [2];
    logic [1:0] guardOverflow;
    logic [1:0] saturated;
    logic [1:0] next_guardOverflow;
    logic [1:0] next_saturated;
    logic [1:0] accWrite;
    logic [1:0] satClear;
    logic [1:0] satEnables;
    logic [15:0] mulX;
    logic [15:0] mulY;
    logic [PROD_W-1:0] product;
    logic [ACC_W-1:0] product40;
    logic [ACC_W-1:0] dataWide;
    logic [ACC_W-1:0] shiftedData;
    logic [ACC_W-1:0] addend;
    logic [ACC_W-1:0] sideA;
    logic [ACC_W-1:0] sideB;
    logic [ACC_W:0] sum41;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] newAcc;
    logic adderOp;
    logic subtract;
    logic catastrophic;
    logic guardMixed;
    logic bit31Overflow;
    logic trueNegative;
    logic satWide;
    logic doSaturate;
    logic setupPhase;
    logic apbWrite;
    logic [31:0] readData;
    logic addrMapped;

    function automatic logic [15:0] extend_operand(input logic [15:0] d, input logic sgn,
                                                   input logic bytes);
        extend_operand = bytes ? {{8{sgn & d[7]}}, d[7:0]} : d;
    endfunction : extend_operand

    function automatic logic guard_mixed(input logic [ACC_W-1:0] v);
        guard_mixed = !((&v[ACC_MSB:GUARD_LO]) || !(|v[ACC_MSB:GUARD_LO]));
    endfunction : guard_mixed

    function automatic logic [ACC_W-1:0] clamp(input logic neg, input logic wide);
        if (wide) begin
            clamp = neg ? SAT39_NEG : SAT39_POS;
        end else begin
            clamp = neg ? SAT31_NEG : SAT31_POS;
        end
    endfunction : clamp

    // multiplier, byte operands are widened to 16 bits first
    assign mulX = extend_operand(opIn.dataX, opIn.xSigned, opIn.byteOps);
    assign mulY = extend_operand(opIn.dataY, opIn.ySigned, opIn.byteOps);

    mac_multiplier u_multiplier (
        .clk_sys(clk_sys),
        .reset(reset),
        .opX(mulX),
        .opY(mulY),
        .xSigned(opIn.xSigned),
        .ySigned(opIn.ySigned),
        .fractional(coreControlReg[CC_FRAC_BIT] && opIn.kind != OP_IMUL),
        .product(product)
    );

    assign satEnables = {coreControlReg[CC_SAT_EN_B_BIT], coreControlReg[CC_SAT_EN_A_BIT]};
    assign satWide = coreControlReg[CC_SATW_BIT];

    always_comb begin
        product40 = {{(ACC_W - PROD_W){product[PROD_W-1]}}, product};
        // word data lands on bits 31:16, positive shift is right, negative left
        dataWide = {{8{opIn.dataIn[15]}}, opIn.dataIn, 16'h0000};
        if (opIn.shiftAmt[4]) begin
            shiftedData = dataWide << 5'(-opIn.shiftAmt);
        end else begin
            shiftedData = $signed(dataWide) >>> opIn.shiftAmt;
        end
        adderOp = opIn.kind == OP_MAC || opIn.kind == OP_ADD || opIn.kind == OP_LOAD;
        addend = (opIn.kind == OP_MAC) ? product40 : shiftedData;
        subtract = opIn.subtract && opIn.kind != OP_LOAD;
        // load zeroes the accumulator side of the adder
        sideA = (opIn.kind == OP_LOAD) ? ACC_RESET : accumulator[opIn.accSel];
        sideB = subtract ? ~addend : addend;
        // carry in high means no borrow when subtracting
        sum41 = {sideA[ACC_MSB], sideA} + {sideB[ACC_MSB], sideB} + {40'h00_0000_0000, subtract};
        sum = sum41[ACC_W-1:0];
        catastrophic = sum41[ACC_W] ^ sum41[ACC_MSB];
        guardMixed = guard_mixed(sum);
        bit31Overflow = guardMixed || (sum[GUARD_LO] ^ sum[GUARD_LO-1]);
        trueNegative = catastrophic ? ~sum[ACC_MSB] : sum[ACC_MSB];
        doSaturate = satEnables[opIn.accSel] &&
                     (satWide ? catastrophic : (catastrophic || bit31Overflow));
        newAcc = doSaturate ? clamp(trueNegative, satWide) : sum;
    end

    // per accumulator state
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_acc
            assign accWrite[g] = opValid && adderOp && opIn.accSel == 1'(g);

            always_comb begin
                next_guardOverflow[g] = accWrite[g] ? guardMixed : guardOverflow[g];
                // a saturation in the clearing cycle wins over the clear
                next_saturated[g] = (accWrite[g] && doSaturate) ||
                                    (saturated[g] && !satClear[g]);
            end

            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    accumulator[g] <= ACC_RESET;
                end else if (accWrite[g]) begin
                    accumulator[g] <= newAcc;
                end
            end

            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    guardOverflow[g] <= 1'b0;
                    saturated[g] <= 1'b0;
                end else begin
                    guardOverflow[g] <= next_guardOverflow[g];
                    saturated[g] <= next_saturated[g];
                end
            end
        end
    endgenerate

    // status mirror for the core status register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            statusOut <= ST_RESET;
        end else begin
            statusOut.accAGuardOverflow <= next_guardOverflow[0];
            statusOut.accBGuardOverflow <= next_guardOverflow[1];
            statusOut.accASaturated <= next_saturated[0];
            statusOut.accBSaturated <= next_saturated[1];
            statusOut.combinedGuardOverflow <= |next_guardOverflow;
            statusOut.combinedSaturated <= |next_saturated;
        end
    end

    // trap only on a fresh rise so a standing overflow does not re-trap
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            trapRequest <= 1'b0;
        end else begin
            trapRequest <= |(accWrite & next_guardOverflow & ~guardOverflow &
                             interruptControlOne);
        end
    end

    // integer multiply result to the working registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mulResult <= 32'h0000_0000;
            mulValid <= 1'b0;
        end else begin
            mulValid <= opValid && opIn.kind == OP_IMUL;
            if (opValid && opIn.kind == OP_IMUL) begin
                mulResult <= opIn.byteOps ? {16'h0000, product[15:0]} : product[31:0];
            end
        end
    end

    // apb slave: zero wait states, data sampled in setup and presented in access
    assign setupPhase = psel && !penable;
    assign apbWrite = psel && penable && pready && pwrite && !pslverr;
    assign satClear = apbWrite && paddr == OFF_STATUS ?
                      {pwdata[ST_SAT_B_BIT], pwdata[ST_SAT_A_BIT]} : 2'b00;

    always_comb begin
        addrMapped = 1'b1;
        readData = 32'h0000_0000;
        unique case (paddr)
            OFF_CORE_CTRL: readData = {24'h00_0000, coreControlReg};
            OFF_INT_CTRL: readData = {30'h0000_0000, interruptControlOne};
            OFF_STATUS: readData = {26'h000_0000, statusOut};
            OFF_ACCA_LO: readData = accumulator[0][31:0];
            OFF_ACCA_HI: readData = {24'h00_0000, accumulator[0][ACC_MSB:GUARD_LO]};
            OFF_ACCB_LO: readData = accumulator[1][31:0];
            OFF_ACCB_HI: readData = {24'h00_0000, accumulator[1][ACC_MSB:GUARD_LO]};
            OFF_MUL_RES: readData = mulResult;
            default: addrMapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase && !addrMapped;
            if (setupPhase && !pwrite) begin
                prdata <= readData;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            coreControlReg <= CC_RESET;
            interruptControlOne <= IC_RESET;
        end else if (apbWrite) begin
            if (paddr == OFF_CORE_CTRL) begin
                coreControlReg <= pwdata[7:0] & CC_WMASK;
            end
            if (paddr == OFF_INT_CTRL) begin
                interruptControlOne <= pwdata[IC_TRAP_EN_B_BIT:IC_TRAP_EN_A_BIT];
            end
        end
    end

    // checks
    property p_mac_accumulates;
        @(posedge clk_sys) disable iff (reset)
        (opValid && opIn.kind == OP_MAC && !opIn.subtract && !opIn.accSel && !doSaturate)
            |=> accumulator[0] == $past(accumulator[0]) + $past(product40);
    endproperty
    a_mac_accumulates: assert property (p_mac_accumulates) else $error("mac sum wrong");

    property p_load_zero_side;
        @(posedge clk_sys) disable iff (reset)
        (accWrite[1] && opIn.kind == OP_LOAD && !doSaturate)
            |=> accumulator[1] == $past(shiftedData);
    endproperty
    a_load_zero_side: assert property (p_load_zero_side) else $error("load not zero based");

    property p_guard_flag;
        @(posedge clk_sys) disable iff (reset)
        (accWrite[0] && !doSaturate) |=> guardOverflow[0] == guard_mixed(accumulator[0]);
    endproperty
    a_guard_flag: assert property (p_guard_flag) else $error("guard flag mismatch");

    property p_guard_follows;
        @(posedge clk_sys) disable iff (reset)
        accWrite[1] ##1 !accWrite[1] [*2] |-> $stable(guardOverflow[1]);
    endproperty
    a_guard_follows: assert property (p_guard_follows) else $error("guard flag moved idle");

    property p_clamp31;
        @(posedge clk_sys) disable iff (reset)
        (accWrite[0] && doSaturate && !satWide)
            |=> accumulator[0] == ($past(trueNegative) ? SAT31_NEG : SAT31_POS);
    endproperty
    a_clamp31: assert property (p_clamp31) else $error("31-bit clamp wrong");

    property p_sat_sets;
        @(posedge clk_sys) disable iff (reset)
        (accWrite[1] && doSaturate) |=> statusOut.accBSaturated && statusOut.combinedSaturated;
    endproperty
    a_sat_sets: assert property (p_sat_sets) else $error("saturated flag not set");

    property p_sat_sticky;
        @(posedge clk_sys) disable iff (reset)
        (saturated[0] && !satClear[0]) |=> saturated[0];
    endproperty
    a_sat_sticky: assert property (p_sat_sticky) else $error("saturated flag dropped");

    property p_combined;
        @(posedge clk_sys) disable iff (reset)
        statusOut.combinedGuardOverflow ==
            (statusOut.accAGuardOverflow || statusOut.accBGuardOverflow);
    endproperty
    a_combined: assert property (p_combined) else $error("combined overflow wrong");

    property p_trap;
        @(posedge clk_sys) disable iff (reset)
        (accWrite[0] && guardMixed && !guardOverflow[0] && interruptControlOne[IC_TRAP_EN_A_BIT])
            |=> trapRequest;
    endproperty
    a_trap: assert property (p_trap) else $error("trap request missing");

    property p_byte_mul;
        @(posedge clk_sys) disable iff (reset)
        (opValid && opIn.kind == OP_IMUL && opIn.byteOps)
            |=> mulValid && mulResult[31:16] == 16'h0000
            ##1 (!mulValid || mulResult == $past(mulResult) || $past(opValid));
    endproperty
    a_byte_mul: assert property (p_byte_mul) else $error("byte multiply result wrong");

    property p_apb_ready;
        @(posedge clk_sys) disable iff (reset)
        setupPhase |=> pready ##1 !pready || setupPhase;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb answer timing wrong");

    c_saturate_a: cover property (@(posedge clk_sys) disable iff (reset)
        accWrite[0] && doSaturate);
    c_catastrophic: cover property (@(posedge clk_sys) disable iff (reset)
        accWrite[1] && catastrophic);
    c_trap: cover property (@(posedge clk_sys) disable iff (reset) trapRequest);
    c_clear_race: cover property (@(posedge clk_sys) disable iff (reset)
        satClear[0] && accWrite[0] && doSaturate);
endmodule : dsp_multiply_accumulate_unit
`default_nettype wire

// ### verification/dsp_core_trap_model.sv
// model of the core side that takes trap requests and multiply results
`default_nettype none
module dsp_core_trap_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // results from the datapath
    input wire logic trapRequest,
    input wire logic mulValid,
    input wire logic [31:0] mulResult,
    // seen by the bench
    output var logic [7:0] trapCount,
    output var logic [31:0] lastMul
);
    timeunit 1ns;
    timeprecision 1ps;
    // a request held for two cycles would count twice, which the bench catches
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            trapCount <= 8'h00;
        end else if (trapRequest) begin
            trapCount <= trapCount + 8'h01;
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lastMul <= 32'h0000_0000;
        end else if (mulValid) begin
            lastMul <= mulResult;
        end
    end
endmodule : dsp_core_trap_model
`default_nettype wire

// ### verification/dsp_multiply_accumulate_unit_tb.sv
// self-checking bench of the multiply-accumulate datapath
`default_nettype none
module dsp_multiply_accumulate_unit_tb
    import dsp_mac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [2:0] sgn;
        logic [31:0] res;
    } mul_row_type;
    // sgn is x signed, y signed, byte operands
    localparam mul_row_type MUL_ROWS [6] = '{
        '{16'hffff, 16'hffff, 3'b000, 32'hfffe_0001},
        '{16'hffff, 16'hffff, 3'b110, 32'h0000_0001},
        '{16'hffff, 16'hffff, 3'b100, 32'hffff_0001},
        '{16'h8000, 16'h8000, 3'b110, 32'h4000_0000},
        '{16'h00ff, 16'h00ff, 3'b001, 32'h0000_fe01},
        '{16'h0080, 16'h007f, 3'b111, 32'h0000_c080}};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic opValid = 1'b0;
    dsp_op_type opIn = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, mulResult, lastMul, rd;
    logic pready, pslverr, mulValid, trapRequest, er;
    dsp_status_type statusOut;
    logic [7:0] trapCount;
    int error_cnt = 0;
    int check_count = 0;

    dsp_multiply_accumulate_unit dut (.clk_sys(clk_sys), .reset(reset), .opValid(opValid),
        .opIn(opIn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mulResult(mulResult), .mulValid(mulValid), .statusOut(statusOut),
        .trapRequest(trapRequest));
    dsp_core_trap_model core (.clk_sys(clk_sys), .reset(reset), .trapRequest(trapRequest),
        .mulValid(mulValid), .mulResult(mulResult), .trapCount(trapCount), .lastMul(lastMul));

    always #20 clk_sys = ~clk_sys;

    task automatic stop_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // a write lands on the access edge, so status is only looked at once it settled
        #1;
    endtask : apb

    task automatic rdAcc(input logic sel, input logic [39:0] exp);
        apb(1'b0, sel ? OFF_ACCB_LO : OFF_ACCA_LO, 32'h0);
        chk(40'(rd), 40'(exp[31:0]));
        apb(1'b0, sel ? OFF_ACCB_HI : OFF_ACCA_HI, 32'h0);
        chk(40'(rd[7:0]), 40'(exp[39:32]));
    endtask : rdAcc

    // changes land on the edge, results are looked at 1 ns after the next one
    task automatic doOp(input op_kind_type k, input logic sel, input logic sub,
                        input logic [15:0] x, input logic [15:0] y, input logic [15:0] d,
                        input logic signed [4:0] sh, input logic [2:0] sgn);
        @(posedge clk_sys);
        opValid <= 1'b1;
        opIn <= '{kind: k, accSel: sel, subtract: sub, xSigned: sgn[2], ySigned: sgn[1],
                  byteOps: sgn[0], shiftAmt: sh, dataX: x, dataY: y, dataIn: d};
        @(posedge clk_sys);
        opValid <= 1'b0;
        #1;
    endtask : doOp

    task automatic addOp(input logic sub, input logic [15:0] d, input logic signed [4:0] sh);
        doOp(OP_ADD, 1'b0, sub, 16'h0, 16'h0, d, sh, 3'b110);
    endtask : addOp

    initial begin
        #(40 * 3000);
        error_cnt++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        chk(40'(statusOut), 40'h00);
        apb(1'b0, OFF_CORE_CTRL, 32'h0);
        chk(40'(rd), 40'h01);
        apb(1'b0, OFF_INT_CTRL, 32'h0);
        chk(40'(rd), 40'h00);
        foreach (MUL_ROWS[i]) begin
            doOp(OP_IMUL, 1'b0, 1'b0, MUL_ROWS[i].x, MUL_ROWS[i].y, 16'h0, 5'sd0,
                 MUL_ROWS[i].sgn);
            chk(40'(mulValid), 40'h01);
            chk(40'(mulResult), 40'(MUL_ROWS[i].res));
        end
        @(posedge clk_sys);
        #1;
        chk(40'(mulValid), 40'h00);
        chk(40'(lastMul), 40'h00_0000_c080);
        // fractional 0.25 then -1.0 times 0.5 into accumulator A
        doOp(OP_MAC, 1'b0, 1'b0, 16'h4000, 16'h4000, 16'h0, 5'sd0, 3'b110);
        rdAcc(1'b0, 40'h00_2000_0000);
        doOp(OP_MAC, 1'b0, 1'b0, 16'h8000, 16'h4000, 16'h0, 5'sd0, 3'b110);
        rdAcc(1'b0, 40'hff_e000_0000);
        chk(40'(statusOut), 40'h00);
        apb(1'b1, OFF_CORE_CTRL, 32'h0);
        doOp(OP_MAC, 1'b1, 1'b0, 16'h4000, 16'h4000, 16'h0, 5'sd0, 3'b110);
        rdAcc(1'b1, 40'h00_1000_0000);
        rdAcc(1'b0, 40'hff_e000_0000);
        doOp(OP_LOAD, 1'b1, 1'b0, 16'h0, 16'h0, 16'h4000, 5'sd4, 3'b110);
        rdAcc(1'b1, 40'h00_0400_0000);
        apb(1'b1, OFF_INT_CTRL, 32'h1);
        doOp(OP_LOAD, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0, 5'sd0, 3'b110);
        addOp(1'b0, 16'h4000, -5'sd8);
        chk(40'(statusOut), 40'h11);
        chk(40'(trapRequest), 40'h01);
        addOp(1'b1, 16'h4000, -5'sd8);
        chk(40'(statusOut), 40'h00);
        rdAcc(1'b0, 40'h0);
        // 32-bit saturation on A, then sticky flag and software clear
        apb(1'b1, OFF_CORE_CTRL, 32'h80);
        addOp(1'b0, 16'h7fff, 5'sd0);
        addOp(1'b0, 16'h7fff, 5'sd0);
        chk(40'(statusOut), 40'h24);
        rdAcc(1'b0, 40'h00_7fff_ffff);
        addOp(1'b1, 16'h7fff, 5'sd0);
        chk(40'(statusOut), 40'h24);
        apb(1'b1, OFF_STATUS, 32'h4);
        chk(40'(statusOut), 40'h00);
        // 40-bit saturation on a catastrophic overflow
        doOp(OP_LOAD, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0, 5'sd0, 3'b110);
        apb(1'b1, OFF_CORE_CTRL, 32'h90);
        addOp(1'b0, 16'h4000, -5'sd8);
        addOp(1'b0, 16'h4000, -5'sd8);
        chk(40'(statusOut), 40'h35);
        rdAcc(1'b0, 40'h7f_ffff_ffff);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(40'(rd[5:0]), 40'h35);
        chk(40'(trapCount), 40'h02);
        // an idle kind with the strobe up must leave the accumulator alone
        doOp(OP_NONE, 1'b0, 1'b0, 16'h0, 16'h0, 16'h7fff, 5'sd0, 3'b110);
        rdAcc(1'b0, 40'h7f_ffff_ffff);
        // accumulator B: guard trap, then 32-bit clamp and clear of both flags
        apb(1'b1, OFF_INT_CTRL, 32'h2);
        doOp(OP_LOAD, 1'b1, 1'b0, 16'h0, 16'h0, 16'h4000, -5'sd8, 3'b110);
        chk(40'(trapRequest), 40'h01);
        chk(40'(statusOut), 40'h37);
        apb(1'b1, OFF_CORE_CTRL, 32'h40);
        doOp(OP_ADD, 1'b1, 1'b0, 16'h0, 16'h0, 16'h0, 5'sd0, 3'b110);
        chk(40'(statusOut), 40'h3f);
        chk(40'(trapRequest), 40'h00);
        rdAcc(1'b1, 40'h00_7fff_ffff);
        apb(1'b1, OFF_STATUS, 32'hc);
        chk(40'(statusOut), 40'h13);
        chk(40'(trapCount), 40'h03);
        apb(1'b0, 8'h20, 32'h0);
        chk(40'(er), 40'h01);
        // reset in mid-run brings every register back to its idle value
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        chk(40'(statusOut), 40'h00);
        chk(40'(trapCount), 40'h00);
        rdAcc(1'b1, 40'h0);
        apb(1'b0, OFF_CORE_CTRL, 32'h0);
        chk(40'(rd), 40'h01);
        stop_test();
    end
endmodule : dsp_multiply_accumulate_unit_tb
`default_nettype wire
